/* design/smr_top.sv */
// select, ready and interlock logic of one storage module with its register slave
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`default_nettype none
module smr_top
  import smr_pkg::*;
#(
  parameter int N_HEADS = 100
) (
  // clock, reset, enable
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic CLK_EN_IN,
  // avalon-mm slave
  input wire logic [SMR_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [SMR_DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [SMR_DATA_W-1:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // drive status inputs, asynchronous
  input wire logic SPEED_OK_IN,
  input wire logic AIR_READY_IN,
  input wire logic AIR_NOT_READY_IN,
  input wire logic [SMR_DISKS-1:0] CW_TOUCH_IN,
  input wire logic [SMR_DISKS-1:0] CCW_TOUCH_IN,
  input wire logic TOUCH_RESET_IN,
  input wire logic LOCAL_SEL_IN,
  input wire logic NEAR_SPEED_IN,
  // partner select and control levels, asynchronous
  input wire logic MODULE_DESIGNATE_IN,
  input wire logic MOTOR_START_IN,
  input wire logic [SMR_DISKS-1:0] DISK_SELECT_N_IN,
  input wire logic [SMR_ZONES-1:0] ZONE_SELECT_N_IN,
  input wire logic [SMR_TRACK_W-1:0] HEAD_TRACK_IN,
  input wire logic WRITE_SELECT_N_IN,
  input wire logic WRITE_ONE_LEVEL_IN,
  input wire logic BIT_PULSE_IN,
  input wire logic INTERLACE_ACTIVE_IN,
  input wire logic INDEX_HOLDOVER_IN,
  input wire logic ADDR_FLUX_IN,
  input wire logic GAIN_SELECT_IN,
  input wire logic THRESHOLD_IN,
  // ready and interlock outputs
  output logic UNIT_READY_OUT,
  output logic READY_TO_PARTNER_OUT,
  output logic SOLENOID_DRIVE_OUT,
  output logic SPEED_OK_OUT,
  output logic LOCAL_MODE_LEVEL_OUT,
  output logic MOTOR_POWER_RELAY_OUT,
  output logic MOTOR_START_NEXT_OUT,
  // select outputs
  output logic LOWER_FACE_SEL_OUT,
  output logic UPPER_FACE_SEL_OUT,
  output logic SEG_OPT_A_OUT,
  output logic SEG_OPT_B_OUT,
  output logic [N_HEADS-1:0] HEAD_POS_SELECT_OUT,
  output logic [SMR_DISKS-1:0] DISK_TAP_OUT,
  output logic [SMR_DISKS*SMR_ZONES-1:0] CLOCK_TAP_SELECT_OUT,
  // read and write path levels
  output logic WRITE_CURRENT_EN_OUT,
  output logic WRITE_BIT_OUT,
  output logic ADDR_READ_OUT,
  output logic THRESHOLD_DETECT_OUT,
  output logic LOW_GAIN_OUT
);

  // refuse geometries the track decoder cannot serve
  if (N_HEADS < 2 || N_HEADS > (1 << SMR_TRACK_W) || (N_HEADS % 2) != 0) begin : g_chk
    $error("N_HEADS must be even and fit the track number width");
  end

  localparam int HALF_HEADS = N_HEADS / 2;
  localparam logic [SMR_TRACK_W-1:0] FACE_SPLIT = SMR_TRACK_W'(HALF_HEADS);
  localparam logic [SMR_TRACK_W-1:0] TRACK_LIMIT = SMR_TRACK_W'(N_HEADS);

  typedef struct packed {
    logic [SI_W-1:0] sync1;
    logic [SI_W-1:0] sync2;
    logic bit_d;
    logic aflux_d;
    logic thr_d;
    logic [SMR_DISKS-1:0] cw_latch;
    logic [SMR_DISKS-1:0] ccw_latch;
    logic [1:0] seg_sel;
    logic motor_on;
    logic retract;
    logic unit_ready;
    logic partner_ready;
    logic solenoid;
    logic speed;
    logic local_lvl;
    logic motor_pwr;
    logic start_next;
    logic lower_face;
    logic upper_face;
    logic seg_a;
    logic seg_b;
    logic [N_HEADS-1:0] head_sel;
    logic [SMR_DISKS-1:0] disk_tap;
    logic [SMR_DISKS*SMR_ZONES-1:0] clk_tap;
    logic wr_cur;
    logic wr_bit;
    logic addr_rd;
    logic thr_pulse;
    logic low_gain;
    logic wait_rq;
    logic [SMR_DATA_W-1:0] rdata;
  } smr_state_t;

  // reset image: idle bus busy, lower face selected, motor switch on
  function automatic smr_state_t reset_state();
    smr_state_t r;
    r = '0;
    r.wait_rq = 1'b1;
    r.lower_face = 1'b1;
    r.seg_sel = SMR_SEG_RST;
    r.motor_on = SMR_MOTOR_ON_RST;
    r.retract = SMR_RETRACT_RST;
    return r;
  endfunction

  // true when exactly one bit is set; used for disk and zone selects
  function automatic logic one_hot8(input logic [7:0] v);
    one_hot8 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction

  smr_state_t st_ff;
  smr_state_t nxt_st;

  logic [SI_W-1:0] raw_in;

  // gather every asynchronous pin into one vector for the synchroniser
  assign raw_in = {THRESHOLD_IN, GAIN_SELECT_IN, ADDR_FLUX_IN, INDEX_HOLDOVER_IN,
                   INTERLACE_ACTIVE_IN, BIT_PULSE_IN, WRITE_ONE_LEVEL_IN,
                   WRITE_SELECT_N_IN, HEAD_TRACK_IN, ZONE_SELECT_N_IN,
                   DISK_SELECT_N_IN, NEAR_SPEED_IN, MOTOR_START_IN,
                   MODULE_DESIGNATE_IN, LOCAL_SEL_IN, TOUCH_RESET_IN,
                   CCW_TOUCH_IN, CW_TOUCH_IN, AIR_NOT_READY_IN, AIR_READY_IN,
                   SPEED_OK_IN};

  // next-state logic for the whole block
  always_comb begin
    logic speed_s;
    logic air_s;
    logic local_s;
    logic desig_s;
    logic treset_s;
    logic touched;
    logic disks_ok;
    logic zones_ok;
    logic write_s;
    logic ilace_s;
    logic bit_edge;
    logic [SMR_DISKS-1:0] disk_s;
    logic [SMR_ZONES-1:0] zone_s;
    logic [SMR_TRACK_W-1:0] track_s;
    logic [SMR_DATA_W-1:0] rd_val;
    logic req;
    speed_s = 1'b0;
    air_s = 1'b0;
    local_s = 1'b0;
    desig_s = 1'b0;
    treset_s = 1'b0;
    touched = 1'b0;
    disks_ok = 1'b0;
    zones_ok = 1'b0;
    write_s = 1'b0;
    ilace_s = 1'b0;
    bit_edge = 1'b0;
    disk_s = '0;
    zone_s = '0;
    track_s = '0;
    rd_val = '0;
    req = 1'b0;
    nxt_st = st_ff;

    // two-stage synchroniser; only the second stage is read below
    nxt_st.sync1 = raw_in;
    nxt_st.sync2 = st_ff.sync1;

    // decode synchronised levels into positive-true conditions
    speed_s = st_ff.sync2[SI_SPEED];
    // complementary pressure inputs; any disagreement counts as low pressure
    air_s = st_ff.sync2[SI_AIR_RDY] & ~st_ff.sync2[SI_AIR_NRDY];
    local_s = st_ff.sync2[SI_LOCAL];
    desig_s = st_ff.sync2[SI_DESIG];
    treset_s = st_ff.sync2[SI_TRESET];
    disk_s = ~st_ff.sync2[SI_DISK_N +: SMR_DISKS];
    zone_s = ~st_ff.sync2[SI_ZONE_N +: SMR_ZONES];
    track_s = st_ff.sync2[SI_TRACK +: SMR_TRACK_W];
    write_s = ~st_ff.sync2[SI_WSEL_N];
    ilace_s = st_ff.sync2[SI_ILACE];

    // touch latches: a contact in the reset cycle still latches
    nxt_st.cw_latch = (treset_s ? '0 : st_ff.cw_latch)
                      | st_ff.sync2[SI_CW +: SMR_DISKS];
    nxt_st.ccw_latch = (treset_s ? '0 : st_ff.ccw_latch)
                       | st_ff.sync2[SI_CCW +: SMR_DISKS];
    touched = (|st_ff.cw_latch) | (|st_ff.ccw_latch);

    // ready and interlock levels
    nxt_st.speed = speed_s;
    nxt_st.unit_ready = (speed_s & ~touched & air_s) | (local_s & ~desig_s);
    // partner sees ready only in remote, so a local module never answers
    nxt_st.partner_ready = speed_s & ~touched & air_s & ~local_s;
    nxt_st.local_lvl = local_s;
    // retract bit lets software drop the heads without touching the motor
    nxt_st.solenoid = ~touched & speed_s & st_ff.motor_on & ~st_ff.retract;

    // motor sequencing down the string of modules
    nxt_st.motor_pwr = st_ff.sync2[SI_MSTART] & st_ff.motor_on;
    nxt_st.start_next = st_ff.motor_pwr & st_ff.sync2[SI_NEAR];

    // face select follows the track half, always complementary
    nxt_st.lower_face = (track_s < FACE_SPLIT);
    nxt_st.upper_face = ~(track_s < FACE_SPLIT);

    // segment option levels from the control register
    unique case (st_ff.seg_sel)
      SMR_SEG_240: begin
        nxt_st.seg_a = 1'b1;
        nxt_st.seg_b = 1'b0;
      end
      SMR_SEG_480: begin
        nxt_st.seg_a = 1'b0;
        nxt_st.seg_b = 1'b1;
      end
      default: begin
        nxt_st.seg_a = 1'b0;
        nxt_st.seg_b = 1'b0;
      end
    endcase

    // one head line at most; out-of-range numbers select none
    nxt_st.head_sel = '0;
    for (int h = 0; h < N_HEADS; h++) begin
      nxt_st.head_sel[h] = (track_s < TRACK_LIMIT)
                           && (track_s == SMR_TRACK_W'(h));
    end

    // disk and zone taps only for an unambiguous single select
    disks_ok = one_hot8({4'h0, disk_s});
    zones_ok = one_hot8({5'h00, zone_s});
    nxt_st.disk_tap = disks_ok ? disk_s : '0;
    for (int d = 0; d < SMR_DISKS; d++) begin
      for (int z = 0; z < SMR_ZONES; z++) begin
        nxt_st.clk_tap[d*SMR_ZONES+z] = disks_ok & zones_ok
                                        & disk_s[d] & zone_s[z];
      end
    end

    // write path: current only in active words, bit ff on bit-clock edges
    nxt_st.wr_cur = write_s & ilace_s;
    nxt_st.bit_d = st_ff.sync2[SI_BIT];
    bit_edge = st_ff.sync2[SI_BIT] & ~st_ff.bit_d;
    if (write_s && ilace_s && bit_edge) begin
      nxt_st.wr_bit = st_ff.sync2[SI_WONE];
    end

    // address-read ff toggles per flux pulse; holdover reset dominates
    nxt_st.aflux_d = st_ff.sync2[SI_AFLUX];
    if (st_ff.sync2[SI_INDEX]) begin
      nxt_st.addr_rd = 1'b0;
    end else if (st_ff.sync2[SI_AFLUX] && !st_ff.aflux_d) begin
      nxt_st.addr_rd = ~st_ff.addr_rd;
    end

    // threshold crossing gives a one-cycle pulse; gain level is followed
    nxt_st.thr_d = st_ff.sync2[SI_THR];
    nxt_st.thr_pulse = st_ff.sync2[SI_THR] & ~st_ff.thr_d;
    nxt_st.low_gain = st_ff.sync2[SI_GAIN];

    // register read mux, unmapped offsets read as zero
    unique case (AVS_ADDRESS_IN)
      SMR_REG_CTRL: begin
        rd_val[SMR_CTRL_SEG_LSB +: 2] = st_ff.seg_sel;
        rd_val[SMR_CTRL_MOTOR_ON] = st_ff.motor_on;
        rd_val[SMR_CTRL_RETRACT] = st_ff.retract;
      end
      SMR_REG_STATUS: begin
        rd_val[SMR_ST_READY] = st_ff.unit_ready;
        rd_val[SMR_ST_AIR] = air_s;
        rd_val[SMR_ST_SPEED] = st_ff.speed;
        rd_val[SMR_ST_LOCAL] = st_ff.local_lvl;
        rd_val[SMR_ST_DESIG] = desig_s;
        rd_val[SMR_ST_SOL] = st_ff.solenoid;
        rd_val[SMR_ST_MOTOR] = st_ff.motor_pwr;
        rd_val[SMR_ST_NEXT] = st_ff.start_next;
        rd_val[SMR_ST_WRITE] = st_ff.wr_cur;
        rd_val[SMR_ST_ADDR] = st_ff.addr_rd;
        rd_val[SMR_ST_GAIN] = st_ff.low_gain;
        rd_val[SMR_ST_PARTNER] = st_ff.partner_ready;
      end
      SMR_REG_TOUCH: begin
        rd_val[SMR_TOUCH_CW_LSB +: SMR_DISKS] = st_ff.cw_latch;
        rd_val[SMR_TOUCH_CCW_LSB +: SMR_DISKS] = st_ff.ccw_latch;
      end
      SMR_REG_SELECT: begin
        rd_val[SMR_SEL_TRACK_LSB +: SMR_TRACK_W] = track_s;
        rd_val[SMR_SEL_DISK_LSB +: SMR_DISKS] = st_ff.disk_tap;
        rd_val[SMR_SEL_ZONE_LSB +: SMR_ZONES] = zone_s;
        rd_val[SMR_SEL_FACE] = st_ff.upper_face;
      end
      default: begin
        rd_val = '0;
      end
    endcase

    // bus handshake: take request, drop waitrequest for one cycle, re-arm
    req = AVS_READ_IN | AVS_WRITE_IN;
    if (req && st_ff.wait_rq) begin
      nxt_st.wait_rq = 1'b0;
      nxt_st.rdata = AVS_READ_IN ? rd_val : '0;
    end else if (req) begin
      nxt_st.wait_rq = 1'b1;
      // write lands on the edge where the master sees waitrequest low
      if (AVS_WRITE_IN && AVS_ADDRESS_IN == SMR_REG_CTRL && AVS_BYTEENABLE_IN[0]) begin
        nxt_st.seg_sel = AVS_WRITEDATA_IN[SMR_CTRL_SEG_LSB +: 2];
        nxt_st.motor_on = AVS_WRITEDATA_IN[SMR_CTRL_MOTOR_ON];
        nxt_st.retract = AVS_WRITEDATA_IN[SMR_CTRL_RETRACT];
      end
    end else begin
      nxt_st.wait_rq = 1'b1;
    end
  end

  // single state register; enable low freezes everything incl. the synchroniser
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      st_ff <= reset_state();
    end else if (CLK_EN_IN) begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from state flops
  assign AVS_READDATA_OUT = st_ff.rdata;
  assign AVS_WAITREQUEST_OUT = st_ff.wait_rq;
  assign UNIT_READY_OUT = st_ff.unit_ready;
  assign READY_TO_PARTNER_OUT = st_ff.partner_ready;
  assign SOLENOID_DRIVE_OUT = st_ff.solenoid;
  assign SPEED_OK_OUT = st_ff.speed;
  assign LOCAL_MODE_LEVEL_OUT = st_ff.local_lvl;
  assign MOTOR_POWER_RELAY_OUT = st_ff.motor_pwr;
  assign MOTOR_START_NEXT_OUT = st_ff.start_next;
  assign LOWER_FACE_SEL_OUT = st_ff.lower_face;
  assign UPPER_FACE_SEL_OUT = st_ff.upper_face;
  assign SEG_OPT_A_OUT = st_ff.seg_a;
  assign SEG_OPT_B_OUT = st_ff.seg_b;
  assign HEAD_POS_SELECT_OUT = st_ff.head_sel;
  assign DISK_TAP_OUT = st_ff.disk_tap;
  assign CLOCK_TAP_SELECT_OUT = st_ff.clk_tap;
  assign WRITE_CURRENT_EN_OUT = st_ff.wr_cur;
  assign WRITE_BIT_OUT = st_ff.wr_bit;
  assign ADDR_READ_OUT = st_ff.addr_rd;
  assign THRESHOLD_DETECT_OUT = st_ff.thr_pulse;
  assign LOW_GAIN_OUT = st_ff.low_gain;

endmodule
`default_nettype wire

/* design/smr_pkg.sv */
// constants, register map and input-vector layout of the module ready logic
// What this block does
// - ready when speed, air, no touch, or local-undesignated
// - air ready only when both pressure inputs agree
// - touch contact latches per disk and direction
// - manual reset clears every touch latch
// - any touch latch drops solenoid, and ready unless local-undesignated
// - solenoid only with no touch and speed
// - speed ok only at nominal rotation speed
// - face selects complementary, split at track fifty
// - two levels encode 480, 240 or 96 segments
// - exactly one head select line per track below N_HEADS, none beyond
// - low disk select becomes that disk's tap
// - disk and zone selects make clock tap
// - motor power only while start input asserted
// - start-next once motor nearly at speed
// - partner ready needs ready, air and remote
// - local level low whenever remote selected
// - write current only during active write word
// - write-one level sets bit flip-flop per bit
// - threshold pulse out, gain select chooses low gain
// - index holdover resets address-read flip-flop
`default_nettype none
package smr_pkg;
  // bus geometry
  localparam int SMR_ADDR_W = 4;
  localparam int SMR_DATA_W = 32;
  // register byte offsets
  localparam logic [3:0] SMR_REG_CTRL = 4'h0;
  localparam logic [3:0] SMR_REG_STATUS = 4'h4;
  localparam logic [3:0] SMR_REG_TOUCH = 4'h8;
  localparam logic [3:0] SMR_REG_SELECT = 4'hc;
  // control register fields and reset values
  localparam int SMR_CTRL_SEG_LSB = 0;
  localparam int SMR_CTRL_MOTOR_ON = 2;
  localparam int SMR_CTRL_RETRACT = 3;
  localparam logic [1:0] SMR_SEG_RST = 2'h0;
  localparam logic SMR_MOTOR_ON_RST = 1'b1;
  localparam logic SMR_RETRACT_RST = 1'b0;
  // segment size codes
  localparam logic [1:0] SMR_SEG_96 = 2'h0;
  localparam logic [1:0] SMR_SEG_240 = 2'h1;
  localparam logic [1:0] SMR_SEG_480 = 2'h2;
  // status register bits
  localparam int SMR_ST_READY = 0;
  localparam int SMR_ST_AIR = 1;
  localparam int SMR_ST_SPEED = 2;
  localparam int SMR_ST_LOCAL = 3;
  localparam int SMR_ST_DESIG = 4;
  localparam int SMR_ST_SOL = 5;
  localparam int SMR_ST_MOTOR = 6;
  localparam int SMR_ST_NEXT = 7;
  localparam int SMR_ST_WRITE = 8;
  localparam int SMR_ST_ADDR = 9;
  localparam int SMR_ST_GAIN = 10;
  localparam int SMR_ST_PARTNER = 11;
  // touch and select register fields
  localparam int SMR_TOUCH_CW_LSB = 0;
  localparam int SMR_TOUCH_CCW_LSB = 8;
  localparam int SMR_SEL_TRACK_LSB = 0;
  localparam int SMR_SEL_DISK_LSB = 8;
  localparam int SMR_SEL_ZONE_LSB = 12;
  localparam int SMR_SEL_FACE = 16;
  // geometry
  localparam int SMR_DISKS = 4;
  localparam int SMR_ZONES = 3;
  localparam int SMR_TRACK_W = 7;
  // positions in the synchronised input vector
  localparam int SI_SPEED = 0;
  localparam int SI_AIR_RDY = 1;
  localparam int SI_AIR_NRDY = 2;
  localparam int SI_CW = 3;
  localparam int SI_CCW = 7;
  localparam int SI_TRESET = 11;
  localparam int SI_LOCAL = 12;
  localparam int SI_DESIG = 13;
  localparam int SI_MSTART = 14;
  localparam int SI_NEAR = 15;
  localparam int SI_DISK_N = 16;
  localparam int SI_ZONE_N = 20;
  localparam int SI_TRACK = 23;
  localparam int SI_WSEL_N = 30;
  localparam int SI_WONE = 31;
  localparam int SI_BIT = 32;
  localparam int SI_ILACE = 33;
  localparam int SI_INDEX = 34;
  localparam int SI_AFLUX = 35;
  localparam int SI_GAIN = 36;
  localparam int SI_THR = 37;
  localparam int SI_W = 38;
endpackage
`default_nettype wire

/* tb/smr_assertions.sv */
// concurrent checks on the ports of the module ready logic
`default_nettype none
module smr_assertions
  import smr_pkg::*;
#(
  parameter int N_HEADS = 100
) (
  // clock, reset, enable
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic CLK_EN_IN,
  // watched inputs
  input wire logic SPEED_OK_IN,
  input wire logic AIR_READY_IN,
  input wire logic AIR_NOT_READY_IN,
  input wire logic [SMR_DISKS-1:0] CW_TOUCH_IN,
  input wire logic [SMR_DISKS-1:0] CCW_TOUCH_IN,
  input wire logic LOCAL_SEL_IN,
  input wire logic MOTOR_START_IN,
  input wire logic [SMR_TRACK_W-1:0] HEAD_TRACK_IN,
  input wire logic WRITE_SELECT_N_IN,
  input wire logic INTERLACE_ACTIVE_IN,
  input wire logic THRESHOLD_IN,
  // watched outputs
  input wire logic READY_TO_PARTNER_OUT,
  input wire logic SOLENOID_DRIVE_OUT,
  input wire logic SPEED_OK_OUT,
  input wire logic LOCAL_MODE_LEVEL_OUT,
  input wire logic MOTOR_POWER_RELAY_OUT,
  input wire logic LOWER_FACE_SEL_OUT,
  input wire logic UPPER_FACE_SEL_OUT,
  input wire logic SEG_OPT_A_OUT,
  input wire logic SEG_OPT_B_OUT,
  input wire logic [N_HEADS-1:0] HEAD_POS_SELECT_OUT,
  input wire logic WRITE_CURRENT_EN_OUT,
  input wire logic THRESHOLD_DETECT_OUT
);
  logic [2:0] run_ff;
  logic ok;
  // hold checks off until the synchronisers refill
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      run_ff <= 3'h0;
    end else if (run_ff != 3'h7) begin
      run_ff <= run_ff + 3'h1;
    end
  end
  assign ok = run_ff == 3'h7;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN || !CLK_EN_IN);
  // contact, then drive dropped after the latch
  sequence touch_hit;
    ok && (|CW_TOUCH_IN || |CCW_TOUCH_IN);
  endsequence
  sequence drive_dropped;
    !SOLENOID_DRIVE_OUT && !READY_TO_PARTNER_OUT;
  endsequence
  face_compl_a: assert property (LOWER_FACE_SEL_OUT != UPPER_FACE_SEL_OUT)
    else $error("face selects not complementary");
  face_split_a: assert property (ok && $past(HEAD_TRACK_IN, 3) < 7'h64
    |-> UPPER_FACE_SEL_OUT == ($past(HEAD_TRACK_IN, 3) >= 7'h32)) else $error("wrong face");
  head_track_a: assert property (ok
    |-> HEAD_POS_SELECT_OUT == (N_HEADS'(1) << $past(HEAD_TRACK_IN, 3)))
    else $error("head select line wrong");
  seg_excl_a: assert property (!(SEG_OPT_A_OUT && SEG_OPT_B_OUT))
    else $error("segment levels both high");
  partner_gate_a: assert property (ok && READY_TO_PARTNER_OUT |-> $past(AIR_READY_IN, 3)
    && !$past(AIR_NOT_READY_IN, 3) && !$past(LOCAL_SEL_IN, 3)) else $error("partner ready early");
  local_lvl_a: assert property (ok |-> LOCAL_MODE_LEVEL_OUT == $past(LOCAL_SEL_IN, 3))
    else $error("local level wrong");
  speed_follow_a: assert property (ok |-> SPEED_OK_OUT == $past(SPEED_OK_IN, 3))
    else $error("speed level wrong");
  motor_gate_a: assert property (ok && MOTOR_POWER_RELAY_OUT |-> $past(MOTOR_START_IN, 3))
    else $error("motor relay without start");
  sol_gate_a: assert property (ok && SOLENOID_DRIVE_OUT |-> $past(SPEED_OK_IN, 3))
    else $error("solenoid without speed");
  touch_drop_a: assert property (touch_hit |-> ##5 drive_dropped)
    else $error("touch did not drop drive");
  write_gate_a: assert property (ok && WRITE_CURRENT_EN_OUT |->
    !$past(WRITE_SELECT_N_IN, 3) && $past(INTERLACE_ACTIVE_IN, 3)) else $error("stray current");
  thr_pulse_a: assert property (ok && $rose(THRESHOLD_IN) |->
    ##[3:5] (THRESHOLD_DETECT_OUT ##1 !THRESHOLD_DETECT_OUT)) else $error("bad threshold pulse");
endmodule

bind smr_top smr_assertions #(.N_HEADS(N_HEADS)) u_chk (.*);
`default_nettype wire

/* tb/smr_eu_model.sv */
// electronics unit model: select levels, word gating, bit clock and gain control
`default_nettype none
module smr_eu_model
  import smr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // bench commands
  input wire logic [1:0] disk_in,
  input wire logic [1:0] zone_in,
  input wire logic sel_en_in,
  input wire logic word_in,
  input wire logic wr_in,
  input wire logic thr_in,
  // levels to the module
  output logic desig_out,
  output logic [SMR_DISKS-1:0] disk_n_out,
  output logic [SMR_ZONES-1:0] zone_n_out,
  output logic wsel_n_out,
  output logic ilace_out,
  output logic bit_out,
  output logic gain_out
);
  logic [2:0] cnt_ff;
  logic gain_ff;
  // one low line per group while selecting, all high otherwise
  assign desig_out = sel_en_in;
  assign disk_n_out = sel_en_in ? ~(4'h1 << disk_in) : 4'hf;
  assign zone_n_out = sel_en_in ? ~(3'h1 << zone_in) : 3'h7;
  assign ilace_out = word_in;
  assign wsel_n_out = ~(wr_in & word_in);
  assign bit_out = word_in & cnt_ff[2];
  assign gain_out = gain_ff;
  // slow bit clock, still between words
  always_ff @(posedge clk_in) begin
    if (rst_in || !word_in) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
  // a threshold pulse switches to low gain until reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gain_ff <= 1'b0;
    end else if (thr_in) begin
      gain_ff <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the module ready logic
`default_nettype none
module tb_top
  import smr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, rd, wr, wq, speed, air_r, air_nr, tres, loc, near, mstart;
  logic wone, thr, flux, index, sel_en, word, wrq, desig, wsel_n, ilace, bitp, gain;
  logic ur, rtp, sol, spd_o, loc_o, relay, nxt, lf, uf, sa, sb, wce, wbit, adr, thd, lg;
  logic [3:0] addr, be, disk_n, tap;
  logic [1:0] disk_c, zone_c;
  logic [2:0] zone_n;
  logic [6:0] track;
  logic [7:0] touch;
  logic [11:0] ctap;
  logic [31:0] wdata, rdata, q;
  logic [99:0] heads;
  int n_errors, checks_done;
  // speed, air ok, air not ok, local, designate -> ready, to partner, solenoid
  logic [7:0] rdy_tab [7] = '{8'hc7, 8'ha1, 8'he1, 8'h40, 8'h34, 8'h38, 8'hd5};
  logic [6:0] tracks [5] = '{7'h0, 7'h31, 7'h32, 7'h63, 7'h64};
  smr_eu_model u_eu (.clk_in(clk), .rst_in(srst), .disk_in(disk_c), .zone_in(zone_c),
    .sel_en_in(sel_en), .word_in(word), .wr_in(wrq), .thr_in(thd), .desig_out(desig),
    .disk_n_out(disk_n), .zone_n_out(zone_n), .wsel_n_out(wsel_n), .ilace_out(ilace),
    .bit_out(bitp), .gain_out(gain));
  smr_top #(.N_HEADS(100)) uut (.SYS_CLK_IN(clk), .SRST_IN(srst), .CLK_EN_IN(1'b1),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wq),
    .SPEED_OK_IN(speed), .AIR_READY_IN(air_r), .AIR_NOT_READY_IN(air_nr),
    .CW_TOUCH_IN(touch[3:0]), .CCW_TOUCH_IN(touch[7:4]), .TOUCH_RESET_IN(tres),
    .LOCAL_SEL_IN(loc), .NEAR_SPEED_IN(near), .MODULE_DESIGNATE_IN(desig),
    .MOTOR_START_IN(mstart), .DISK_SELECT_N_IN(disk_n), .ZONE_SELECT_N_IN(zone_n),
    .HEAD_TRACK_IN(track), .WRITE_SELECT_N_IN(wsel_n), .WRITE_ONE_LEVEL_IN(wone),
    .BIT_PULSE_IN(bitp), .INTERLACE_ACTIVE_IN(ilace), .INDEX_HOLDOVER_IN(index),
    .ADDR_FLUX_IN(flux), .GAIN_SELECT_IN(gain), .THRESHOLD_IN(thr), .UNIT_READY_OUT(ur),
    .READY_TO_PARTNER_OUT(rtp), .SOLENOID_DRIVE_OUT(sol), .SPEED_OK_OUT(spd_o),
    .LOCAL_MODE_LEVEL_OUT(loc_o), .MOTOR_POWER_RELAY_OUT(relay), .MOTOR_START_NEXT_OUT(nxt),
    .LOWER_FACE_SEL_OUT(lf), .UPPER_FACE_SEL_OUT(uf), .SEG_OPT_A_OUT(sa),
    .SEG_OPT_B_OUT(sb), .HEAD_POS_SELECT_OUT(heads), .DISK_TAP_OUT(tap),
    .CLOCK_TAP_SELECT_OUT(ctap), .WRITE_CURRENT_EN_OUT(wce), .WRITE_BIT_OUT(wbit),
    .ADDR_READ_OUT(adr), .THRESHOLD_DETECT_OUT(thd), .LOW_GAIN_OUT(lg));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus access, waits for waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wq !== 1'b0) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic chk_rd(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(what, exp, q);
  endtask
  // longest pin-to-output path is four edges, one spare
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask
  initial begin
    {srst, air_nr} = 2'h3;
    {rd, wr, speed, air_r, tres, loc, near, mstart, wone, thr, flux, index} = '0;
    {sel_en, word, wrq, disk_c, zone_c, track, touch, addr, be, wdata} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    chk("lower face", 1'b1, lf);
    chk("relay", 1'b0, relay);
    chk_rd("ctrl", SMR_REG_CTRL, 32'h4);
    chk_rd("unmapped", 4'h2, 32'h0);
    bus(1'b1, 4'h2, 32'h3, 4'hf);
    bus(1'b1, SMR_REG_CTRL, 32'h3, 4'h0);
    chk_rd("ctrl", SMR_REG_CTRL, 32'h4);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, SMR_REG_CTRL, 32'h4 | s, 4'h1);
      settle();
      chk("seg a", s == 1, sa);
      chk("seg b", s == 2, sb);
    end
    chk_rd("ctrl", SMR_REG_CTRL, 32'h7);
    bus(1'b1, SMR_REG_CTRL, 32'h4, 4'h1);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      {speed, air_r, air_nr, loc, sel_en} <= rdy_tab[i][7:3];
      settle();
      chk("ready", rdy_tab[i][2], ur);
      chk("to partner", rdy_tab[i][1], rtp);
      chk("solenoid", rdy_tab[i][0], sol);
      chk("speed", rdy_tab[i][7], spd_o);
      chk("local", rdy_tab[i][4], loc_o);
    end
    {speed, air_r, air_nr, loc, sel_en} <= 5'h18;
    $display("test ready done");
    for (int i = 0; i < 8; i++) begin
      touch <= 8'h1 << i;
      settle();
      touch <= 8'h0;
      settle();
      chk_rd("touch", SMR_REG_TOUCH, 32'h1 << (i < 4 ? i : i + 4));
      chk("ready", 1'b0, ur);
      chk("solenoid", 1'b0, sol);
      tres <= 1'b1;
      settle();
      tres <= 1'b0;
      settle();
      chk_rd("touch", SMR_REG_TOUCH, 32'h0);
      chk("ready", 1'b1, ur);
    end
    $display("test touch done");
    near <= 1'b1;
    settle();
    chk("relay", 1'b0, relay);
    {mstart, near} <= 2'h2;
    settle();
    chk("relay", 1'b1, relay);
    chk("next", 1'b0, nxt);
    near <= 1'b1;
    settle();
    chk("next", 1'b1, nxt);
    bus(1'b1, SMR_REG_CTRL, 32'hc, 4'h1);
    settle();
    chk("solenoid", 1'b0, sol);
    bus(1'b1, SMR_REG_CTRL, 32'h0, 4'h1);
    settle();
    chk("relay", 1'b0, relay);
    bus(1'b1, SMR_REG_CTRL, 32'h4, 4'h1);
    $display("test motor done");
    sel_en <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      for (int z = 0; z < 3; z++) begin
        disk_c <= 2'(d);
        zone_c <= 2'(z);
        settle();
        chk("disk tap", 4'h1 << d, tap);
        chk("clock tap", 12'h1 << (d * 3 + z), ctap);
      end
    end
    sel_en <= 1'b0;
    settle();
    chk("clock tap", 12'h0, ctap);
    foreach (tracks[k]) begin
      track <= tracks[k];
      settle();
      chk("heads", tracks[k] < 7'h64 ? 128'h1 << tracks[k] : 128'h0, heads);
      if (tracks[k] < 7'h64) chk("upper face", tracks[k] >= 7'h32, uf);
    end
    $display("test selects done");
    {wrq, word, wone} <= 3'h7;
    // two and a half periods of the model's bit clock
    repeat (20) @(posedge clk);
    chk("write current", 1'b1, wce);
    chk("write bit", 1'b1, wbit);
    wone <= 1'b0;
    repeat (20) @(posedge clk);
    chk("write bit", 1'b0, wbit);
    word <= 1'b0;
    settle();
    chk("write current", 1'b0, wce);
    $display("test write done");
    chk("low gain", 1'b0, lg);
    thr <= 1'b1;
    settle();
    thr <= 1'b0;
    repeat (3) settle();
    chk("low gain", 1'b1, lg);
    flux <= 1'b1;
    settle();
    flux <= 1'b0;
    settle();
    chk("addr ff", 1'b1, adr);
    index <= 1'b1;
    settle();
    chk("addr ff", 1'b0, adr);
    flux <= 1'b1;
    settle();
    chk("addr ff", 1'b0, adr);
    $display("test read path done");
    close_out();
  end
endmodule
`default_nettype wire
